// ==== src/edge_sync.v ====
// Two-stage synchroniser with rise and fall pulse outputs.
// Assumes the input is asynchronous to clk_sys_in.
`timescale 1ns/1ps
`include "voice_port_defs.vh"
module edge_sync (
    input  wire clk_sys_in,
    input  wire rst_in,
    input  wire pin_in,
    output wire level_out,
    output wire rise_out,
    output wire fall_out
);
    reg stage1;
    reg stage2;
    reg stage3;

    // ------------------------------------------------------------
    // Sync chain; stage1 feeds only stage2
    // ------------------------------------------------------------
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Edges seen on the settled copies
    assign level_out = stage2;
    assign rise_out  = stage2 & ~stage3;
    assign fall_out  = ~stage2 & stage3;
endmodule

// ==== src/voice_i2s_slave_port.v ====
// Slave-side long-sync serial voice port with codec reference clock output.
// Assumes an external master drives bit clock at 256 kHz, word-select at 8 kHz, and
// that a separate two-wire controller passes codec set-up through this block.
`timescale 1ns/1ps
`include "voice_port_defs.vh"
module voice_i2s_slave_port #(
    parameter WORD_BITS  = `VP_WORD_BITS,
    parameter REF_HALF   = `VP_REF_HALF_CYCLES
) (
    input  wire                 clk_sys_in,
    input  wire                 rst_in,
    input  wire                 bit_clock_in,
    input  wire                 word_select_in,
    input  wire                 serial_data_in,
    output reg                  serial_data_out,
    input  wire [WORD_BITS-1:0] tx_left_in,
    input  wire [WORD_BITS-1:0] tx_right_in,
    output wire                 tx_load_out,
    output reg  [WORD_BITS-1:0] rx_left_out,
    output reg  [WORD_BITS-1:0] rx_right_out,
    output reg                  rx_valid_out,
    output reg                  frame_error_out,
    output reg                  codec_ref_clock_pin_out,
    input  wire                 ctrl_scl_in,
    output wire                 ctrl_scl_oe_out,
    input  wire                 ctrl_sda_in,
    output wire                 ctrl_sda_oe_out,
    input  wire                 ctrl_scl_pull_in,
    input  wire                 ctrl_sda_pull_in
);
    localparam CNT_W = 6;
    localparam REF_W = 8;
    // Frame length is cut to the counter width on purpose; 31 fits six bits
    localparam integer     FRAME_LAST_I = `VP_FRAME_BITS - 1;
    localparam [CNT_W-1:0] FRAME_LAST   = FRAME_LAST_I[CNT_W-1:0];

    wire bclk_rise;
    wire bclk_fall;
    wire ws_level;
    wire ws_rise;
    wire ws_fall;
    wire sd_level;

    reg                 ws_seen;
    reg                 ws_prev;
    reg                 word_start;
    reg [CNT_W-1:0]     bit_cnt;
    reg [CNT_W-1:0]     frame_cnt;
    reg                 in_frame;
    reg [WORD_BITS-1:0] tx_shift;
    reg [WORD_BITS-1:0] tx_right_hold;
    reg [WORD_BITS-1:0] rx_shift;
    reg                 rx_chan;
    reg [REF_W-1:0]     ref_cnt;

    // ------------------------------------------------------------
    // Input sampling; bit clock, word-select and serial data only come in
    // ------------------------------------------------------------
    edge_sync u_bclk (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .pin_in     (bit_clock_in),
        .level_out  (),
        .rise_out   (bclk_rise),
        .fall_out   (bclk_fall)
    );

    edge_sync u_ws (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .pin_in     (word_select_in),
        .level_out  (ws_level),
        .rise_out   (ws_rise),
        .fall_out   (ws_fall)
    );

    edge_sync u_sd (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .pin_in     (serial_data_in),
        .level_out  (sd_level),
        .rise_out   (),
        .fall_out   ()
    );

    // Load strobe marks the left word start, where both words are captured.
    // ws_seen already holds the new word-select level here, while ws_prev
    // still holds the old one, so only ws_seen tells left from right.
    assign tx_load_out = bclk_fall & word_start & ~ws_seen;

    // ------------------------------------------------------------
    // Word-select tracking on the bit clock edges; ws_prev moves on the falling edge
    // ------------------------------------------------------------
    // Word-select is sampled on the rising edge; a change means the next
    // falling edge begins the first bit, one clock later.
    // After reset the synchronised copy starts low, so a master that idles
    // with word-select high gives one spurious right-word start; it is
    // harmless, as the first real left word restarts both directions.
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            ws_seen    <= 1'b0;
            ws_prev    <= 1'b0;
            word_start <= 1'b0;
        end else if (bclk_rise) begin
            ws_seen    <= ws_level;
            word_start <= (ws_level != ws_seen);
        end else if (bclk_fall) begin
            ws_prev    <= ws_seen;
        end
    end

    // ------------------------------------------------------------
    // Transmit: load at word start, shift on falling edge, MSB first
    // ------------------------------------------------------------
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            tx_shift        <= {WORD_BITS{1'b0}};
            tx_right_hold   <= {WORD_BITS{1'b0}};
            serial_data_out <= 1'b0;
        end else if (bclk_fall) begin
            if (word_start) begin
                // Left word goes out while word-select is low
                if (!ws_seen) begin
                    serial_data_out <= tx_left_in[WORD_BITS-1];
                    tx_shift        <= {tx_left_in[WORD_BITS-2:0], 1'b0};
                    tx_right_hold   <= tx_right_in;
                end else begin
                    serial_data_out <= tx_right_hold[WORD_BITS-1];
                    tx_shift        <= {tx_right_hold[WORD_BITS-2:0], 1'b0};
                end
            end else begin
                // Bits past the word length are zero padding
                serial_data_out <= tx_shift[WORD_BITS-1];
                tx_shift        <= {tx_shift[WORD_BITS-2:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // Receive: sample on rising edge, sixteen bits per word
    // ------------------------------------------------------------
    // Samples pass through untouched as two's complement; no companding.
    // The first bit is taken one rise after the word start is seen, which
    // is the rise that follows the falling edge carrying the MSB.
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            rx_shift     <= {WORD_BITS{1'b0}};
            bit_cnt      <= {CNT_W{1'b0}};
            rx_chan      <= 1'b0;
            rx_left_out  <= {WORD_BITS{1'b0}};
            rx_right_out <= {WORD_BITS{1'b0}};
            rx_valid_out <= 1'b0;
        end else begin
            rx_valid_out <= 1'b0;
            if (bclk_rise) begin
                if (word_start) begin
                    rx_shift <= {{(WORD_BITS-1){1'b0}}, sd_level};
                    bit_cnt  <= {{(CNT_W-1){1'b0}}, 1'b1};
                    rx_chan  <= ws_prev;
                end else if (bit_cnt != {CNT_W{1'b0}} &&
                             bit_cnt < WORD_BITS[CNT_W-1:0]) begin
                    rx_shift <= {rx_shift[WORD_BITS-2:0], sd_level};
                    bit_cnt  <= bit_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
                    if (bit_cnt == WORD_BITS[CNT_W-1:0] - 1'b1) begin
                        if (rx_chan) begin
                            rx_right_out <= {rx_shift[WORD_BITS-2:0], sd_level};
                            rx_valid_out <= 1'b1;
                        end else begin
                            rx_left_out  <= {rx_shift[WORD_BITS-2:0], sd_level};
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Frame length check: 32 bit clocks per word-select period
    // ------------------------------------------------------------
    // Flags a frame that is not exactly 32 clocks; only clocks per frame are
    // counted, so a master running at the wrong rate with 32 clocks per frame is not caught.
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            frame_cnt       <= {CNT_W{1'b0}};
            in_frame        <= 1'b0;
            frame_error_out <= 1'b0;
        end else if (ws_fall) begin
            in_frame        <= 1'b1;
            frame_cnt       <= {CNT_W{1'b0}};
            frame_error_out <= in_frame && (frame_cnt != FRAME_LAST + 1'b1);
        end else if (bclk_rise && in_frame) begin
            if (frame_cnt != {CNT_W{1'b1}}) begin
                frame_cnt <= frame_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ------------------------------------------------------------
    // Codec reference clock, divided from the system clock
    // ------------------------------------------------------------
    // Free-running and unrelated to the bit clock; the codec locks its own
    // timing to it, not to this port's framing.
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            ref_cnt                 <= {REF_W{1'b0}};
            codec_ref_clock_pin_out <= 1'b0;
        end else if (ref_cnt == REF_HALF[REF_W-1:0] - 1'b1) begin
            ref_cnt                 <= {REF_W{1'b0}};
            codec_ref_clock_pin_out <= ~codec_ref_clock_pin_out;
        end else begin
            ref_cnt <= ref_cnt + {{(REF_W-1){1'b0}}, 1'b1};
        end
    end

    // ------------------------------------------------------------
    // Control bus pass-through, open drain
    // ------------------------------------------------------------
    // The controller itself lives elsewhere; pulls low here only when it
    // asks, so other targets on the same bus are left free.
    assign ctrl_scl_oe_out = ctrl_scl_pull_in;
    assign ctrl_sda_oe_out = ctrl_sda_pull_in;

    // Sampled bus levels are not used locally
    wire unused_ctrl = ctrl_scl_in ^ ctrl_sda_in ^ ws_rise;
endmodule

// ==== src/voice_port_defs.vh ====
// Constants for the serial voice port: framing, rates and reference clock.
// Assumes a 50 MHz system clock; included by the voice port design files.
//
// Notes on behaviour
// - Port is slave only; bit clock and word-select always come from outside.
// - Long-sync I2S framing; word-select low is left word, high is right.
// - Samples are linear two's complement values, no companding.
// - Sixteen-bit words, sixteen bit clocks each, most significant bit first.
// - One word-select period is thirty-two bit clocks holding two words.
// - Sample rate 8 kHz; word-select period is 125 microseconds.
// - Device drives a reference clock for the codec on a dedicated pin.
// - Device configures the codec over its shared two-wire control bus; this block only passes a separate controller's pull requests through.
`ifndef VOICE_PORT_DEFS_VH
`define VOICE_PORT_DEFS_VH

// ------------------------------------------------------------
// Framing
// ------------------------------------------------------------
`define VP_WORD_BITS       16
`define VP_FRAME_BITS      32
`define VP_SAMPLE_RATE_HZ  8000
`define VP_BCLK_HZ         (`VP_FRAME_BITS * `VP_SAMPLE_RATE_HZ)

// ------------------------------------------------------------
// Clocks
// ------------------------------------------------------------
`define VP_SYS_CLK_HZ      50000000
`define VP_REF_CLK_HZ      2048000
`define VP_REF_HALF_CYCLES (`VP_SYS_CLK_HZ / (2 * `VP_REF_CLK_HZ))
`define VP_SYNC_STAGES     2

`endif

// ==== test/codec_master.sv ====
// Behavioural codec acting as bus master: makes bit clock, ws and data.
// Assumes the bench reads sent_q and got_q hierarchically.
`timescale 1ns/1ps
module codec_master (
    input  wire run_in,
    input  wire short_in,
    input  wire sd_from_dut_in,
    output reg  bclk_out = 1'b0,
    output reg  ws_out = 1'b1,
    output reg  sd_to_dut_out = 1'b0
);
    reg [31:0]   sh;
    reg [31:0]   rbit;
    integer      cnt = 31;
    integer      top;
    logic [31:0] sent_q[$];
    logic [31:0] got_q[$];
    // Outputs start idle by declaration, so no false falling edge of the
    // bit clock is seen at time zero
    initial begin
        sh = 32'h0000_0000;
        rbit = 32'h0000_0000;
    end
    // Bit clock stands still until the bench starts the link
    always begin
        #80;
        if (run_in) bclk_out = ~bclk_out;
    end
    // Everything moves on the falling edge; a short frame is 30 clocks
    always @(negedge bclk_out) begin
        top = short_in ? 29 : 31;
        cnt = (cnt >= top) ? 0 : cnt + 1;
        ws_out = cnt > top / 2;
        // Sampled late: the port's sync latency eats half a bit period
        rbit = {rbit[30:0], sd_from_dut_in};
        if (cnt == 1) begin
            got_q.push_back(rbit);
            sh = (sent_q.size() == 0) ? 32'h8000_7FFF : $urandom;
            sent_q.push_back(sh);
        end else begin
            sh = sh << 1;
        end
        sd_to_dut_out = sh[31];
    end
endmodule

// ==== test/voice_i2s_slave_port_tb_top.sv ====
// Bench for the voice port: codec model, scoreboard on both data directions.
// Assumes design sources in src/ and the checker bound separately.
`timescale 1ns/1ps
module voice_i2s_slave_port_tb_top;
    reg          clk_sys_in = 0, rst_in = 1, run = 0, short = 0, ignore = 0;
    reg          scl_pull = 0, sda_pull = 0;
    reg  [15:0]  tx_l = 16'h0000, tx_r = 16'h0000;
    wire         bclk, ws, sd_in, sd_out, load, valid, err, ref_clk, scl_oe, sda_oe;
    wire [15:0]  rx_l, rx_r;
    integer      n_fail = 0, n_checks = 0;
    logic [31:0] exp_q[$], g;
    always #10 clk_sys_in = ~clk_sys_in;
    voice_i2s_slave_port dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .bit_clock_in(bclk), .word_select_in(ws), .serial_data_in(sd_in),
        .serial_data_out(sd_out), .tx_left_in(tx_l), .tx_right_in(tx_r),
        .tx_load_out(load), .rx_left_out(rx_l), .rx_right_out(rx_r),
        .rx_valid_out(valid), .frame_error_out(err), .codec_ref_clock_pin_out(ref_clk),
        .ctrl_scl_in(~scl_oe), .ctrl_scl_oe_out(scl_oe), .ctrl_sda_in(~sda_oe),
        .ctrl_sda_oe_out(sda_oe), .ctrl_scl_pull_in(scl_pull), .ctrl_sda_pull_in(sda_pull));
    codec_master codec_u (.run_in(run), .short_in(short), .sd_from_dut_in(sd_out),
        .bclk_out(bclk), .ws_out(ws), .sd_to_dut_out(sd_in));
    task automatic check(input [31:0] seen, input [31:0] want);
        n_checks = n_checks + 1;
        if (seen !== want) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %0t got %h want %h", $time, seen, want);
        end
    endtask
    task summarize;
        if (n_fail == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Scoreboard; the first capture predates any load and is dropped
    always @(posedge clk_sys_in) begin
        if (!ignore && valid) check({rx_l, rx_r}, codec_u.sent_q.pop_front());
        if (codec_u.got_q.size() > 0) begin
            g = codec_u.got_q.pop_front();
            if (!ignore && exp_q.size() > 0) check(g, exp_q.pop_front());
        end
        if (load) begin
            exp_q.push_back({tx_l, tx_r});
            #1 {tx_l, tx_r} = $urandom;
        end
    end
    // Random control-bus pull requests
    always @(posedge clk_sys_in) begin
        #1 {scl_pull, sda_pull} = $urandom;
    end
    initial begin
        void'($urandom(32'h03FD5A4D));
        {tx_l, tx_r} = 32'h7FFF_8000;
        repeat (4) @(posedge clk_sys_in);
        #1 rst_in = 0;
        run = 1;
        repeat (5000) @(posedge clk_sys_in);
        check(err, 0);
        // Short frames break data alignment, so data checks stop for the rest of the run
        #1 ignore = 1;
        short = 1;
        repeat (800) @(posedge clk_sys_in);
        check(err, 1);
        #1 short = 0;
        repeat (800) @(posedge clk_sys_in);
        check(err, 0);
        summarize;
    end
    initial begin
        #1000000;
        n_fail = n_fail + 1;
        summarize;
    end
endmodule

// ==== test/voice_port_chk.sv ====
// Checker for the voice port: pulse shapes, pin timing, reference clock.
// Assumes it is bound onto voice_i2s_slave_port and sees only its ports.
`timescale 1ns/1ps
module voice_port_chk #(parameter REF_HALF = 12) (
    input wire clk_sys_in,
    input wire rst_in,
    input wire bit_clock_in,
    input wire word_select_in,
    input wire serial_data_out,
    input wire tx_load_out,
    input wire rx_valid_out,
    input wire frame_error_out,
    input wire codec_ref_clock_pin_out,
    input wire ctrl_scl_pull_in,
    input wire ctrl_sda_pull_in,
    input wire ctrl_scl_oe_out,
    input wire ctrl_sda_oe_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    reg [7:0] cnt;
    reg       seen;
    // Cycles since the last reference edge; the first edge is not timed
    always @(posedge clk_sys_in) begin
        cnt  <= (rst_in || $changed(codec_ref_clock_pin_out)) ? 8'h00 : cnt + 8'h01;
        seen <= rst_in ? 1'b0 : (seen || $changed(codec_ref_clock_pin_out));
    end
    property p_ref; seen && $changed(codec_ref_clock_pin_out) |-> cnt == REF_HALF - 1; endproperty
    a_ref: assert property (p_ref) else $error("reference half period wrong");
    property p_scl; ctrl_scl_oe_out == ctrl_scl_pull_in; endproperty
    a_scl: assert property (p_scl) else $error("scl pull not passed");
    property p_sda; ctrl_sda_oe_out == ctrl_sda_pull_in; endproperty
    a_sda: assert property (p_sda) else $error("sda pull not passed");
    property p_load; tx_load_out |=> !tx_load_out [*8]; endproperty
    a_load: assert property (p_load) else $error("load pulse too long");
    property p_valid; rx_valid_out |=> !rx_valid_out [*8]; endproperty
    a_valid: assert property (p_valid) else $error("valid pulse too long");
    property p_sd; $changed(serial_data_out) |-> !$past(bit_clock_in, 2); endproperty
    a_sd: assert property (p_sd) else $error("data moved off a falling edge");
    property p_ldws; tx_load_out |-> !$past(word_select_in, 6); endproperty
    a_ldws: assert property (p_ldws) else $error("load outside left word");
    property p_err;
        $changed(frame_error_out) |-> !$past(word_select_in, 2) && $past(word_select_in, 20);
    endproperty
    a_err: assert property (p_err) else $error("error flag moved off ws fall");
    c_load: cover property (tx_load_out);
    c_valid: cover property (rx_valid_out);
    c_err: cover property ($rose(frame_error_out));
endmodule
bind voice_i2s_slave_port voice_port_chk #(.REF_HALF(REF_HALF)) chk_u (.*);
